//--- exms_pkg.sv
// Function
// - Fault inside a microsequence escalates one class
// - Fault during reset sequence restarts reset sequence
// - Style clear: indexed call, offsets zero and code
// - Style set: process switch via fixed vector
// - Second index is saved code shifted three
// - Indexed call ends with status 7, 1, 3
// - Normal codes 0 to 7 fixed encoding
// - Normal codes 8,9,10,14,15; 11-13 unused
// - Trace trap at instruction end when enabled
// - Overflow trap only when enabled, may defer
// - Misaligned access raises external memory code unless ABA is set
// - Zero divide always on; some update flags
// - Stack fault during indexed call escalates
// - Stack class: push pointer, save, switch
// - Stack class status words 7,0,3 and code
// - Stack codes 0 bound, 1 store, 3 fetch
// - Process class: no save, push, load vector
// - Process class handler keeps copied code
// - Exception type 0 reset up to 3 normal
// - Idle status reads type 3, code 7
// - Process codes 0 old, 1 gate, 4 new
package exms_pkg;
    // ==================================================
    // Exception types
    localparam logic [1:0] ET_RESET   = 2'h0;
    localparam logic [1:0] ET_PROCESS = 2'h1;
    localparam logic [1:0] ET_STACK   = 2'h2;
    localparam logic [1:0] ET_NORMAL  = 2'h3;
    // ==================================================
    // Internal state codes
    localparam logic [3:0] ISC_ZDIV  = 4'h0;
    localparam logic [3:0] ISC_TRACE = 4'h1;
    localparam logic [3:0] ISC_EXTM  = 4'h5;
    localparam logic [3:0] ISC_IDLE  = 4'h7;
    localparam logic [3:0] ISC_INVD  = 4'h4;
    localparam logic [3:0] ISC_RDT   = 4'h8;
    localparam logic [3:0] ISC_OVF   = 4'h9;
    localparam logic [3:0] ISC_PREG  = 4'hf;
    localparam logic [3:0] ISC_SBND  = 4'h0;
    localparam logic [3:0] ISC_SFLT  = 4'h1;
    localparam logic [3:0] ISC_SIDF  = 4'h3;
    localparam logic [3:0] ISC_POLD  = 4'h0;
    localparam logic [3:0] ISC_PNEW  = 4'h4;
    // ==================================================
    // Fixed vector locations
    localparam logic [31:0] VEC_NRM = 32'h0000_0484;
    localparam logic [31:0] VEC_STK = 32'h0000_0088;
    localparam logic [31:0] VEC_PRC = 32'h0000_0084;
    localparam logic [31:0] VEC_RST = 32'h0000_0080;
    localparam logic [7:0]  GATE_IDX1 = 8'h00;
    localparam logic [1:0]  SEQ_LAST  = 2'h2;
    // ==================================================
    // Register map
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_STAT  = 4'h4;
    localparam logic [3:0] OFS_SAVED = 4'h8;
    localparam logic [3:0] OFS_VEC   = 4'hc;
    localparam int B_HSS = 0;
    localparam int B_TE  = 1;
    localparam int B_OE  = 2;
    localparam int B_ABA = 3;
    localparam int B_BUSY = 8;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // ==================================================
    typedef struct packed {
        logic [3:0] internal_state_code;
        logic       tm;
        logic [1:0] et;
    } exms_psw_t;
    typedef struct packed {
        logic       valid;
        logic [1:0] et;
        logic [3:0] internal_state_code;
    } exms_req_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RUN  = 2'b01,
        S_DONE = 2'b10
    } exms_state_t;
    localparam exms_psw_t PSW_IDLE = '{internal_state_code: 4'h7, tm: 1'b0, et: 2'h3};
    localparam exms_psw_t PSW_GATE = '{internal_state_code: 4'h7, tm: 1'b1, et: 2'h3};
endpackage : exms_pkg

//--- exms_core.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
module exms_core
    import exms_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData_reg,
    // Core event inputs
    input  wire logic        fltValid,
    input  wire logic [3:0]  fltCode,
    input  wire logic        instrEnd,
    input  wire logic        ovfDet,
    input  wire logic        misalign,
    input  wire logic        stackBound,
    input  wire logic        idFetchFault,
    // Memory fault pin
    input  wire logic        memFault,
    // Sequencer outputs
    output logic             seqBusy_reg,
    output logic             seqDone_reg,
    output logic             ctxSave_reg,
    output logic             pushPcbp_reg,
    output logic             flagsUpd_reg,
    output logic      [7:0]  gateIdx1_reg,
    output logic      [7:0]  gateIdx2_reg,
    output logic      [31:0] vecAddr_reg,
    output exms_psw_t        psw_reg,
    output exms_psw_t        savedPsw_reg
);
    // ==================================================
    // Synchroniser and control
    logic        faultMeta_reg;
    logic        faultSync_reg;
    logic [3:0]  ctrl_reg;
    logic        ovfPend_reg;
    exms_state_t state_reg;
    logic [1:0]  curEt_reg;
    logic [3:0]  curIsc_reg;
    logic [1:0]  step_reg;
    exms_req_t   reqSel;
    logic [3:0]  escIsc;
    logic        escEv;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            faultMeta_reg <= 1'b0;
            faultSync_reg <= 1'b0;
        end else begin
            faultMeta_reg <= memFault;
            faultSync_reg <= faultMeta_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (regWr && regAddr == OFS_CTRL) begin
            ctrl_reg <= regWrData[3:0];
        end
    end

    // Overflow may trail its instruction by one; it waits here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ovfPend_reg <= 1'b0;
        end else if (ovfDet && ctrl_reg[B_OE]) begin
            ovfPend_reg <= 1'b1;
        end else if (state_reg == S_IDLE && reqSel.internal_state_code == ISC_OVF
                     && reqSel.et == ET_NORMAL) begin
            ovfPend_reg <= 1'b0;
        end
    end

    // ==================================================
    // Request selection, most severe first
    always_comb begin
        reqSel = '{valid: 1'b0, et: ET_NORMAL, internal_state_code: ISC_IDLE};
        if (idFetchFault) begin
            reqSel = '{valid: 1'b1, et: ET_STACK, internal_state_code: ISC_SIDF};
        end else if (faultSync_reg) begin
            reqSel = '{valid: 1'b1, et: ET_NORMAL, internal_state_code: ISC_EXTM};
        end else if (fltValid) begin
            reqSel = '{valid: 1'b1, et: ET_NORMAL, internal_state_code: fltCode};
        end else if (misalign && !ctrl_reg[B_ABA]) begin
            reqSel = '{valid: 1'b1, et: ET_NORMAL, internal_state_code: ISC_EXTM};
        end else if (ovfPend_reg) begin
            reqSel = '{valid: 1'b1, et: ET_NORMAL, internal_state_code: ISC_OVF};
        end else if (instrEnd && ctrl_reg[B_TE]) begin
            reqSel = '{valid: 1'b1, et: ET_NORMAL, internal_state_code: ISC_TRACE};
        end
    end

    // Escalation cause and code for the next class
    always_comb begin
        escEv  = faultSync_reg;
        escIsc = curIsc_reg;
        unique case (curEt_reg)
            ET_NORMAL: begin
                escEv  = faultSync_reg || (stackBound && step_reg == 2'h0);
                escIsc = (stackBound && step_reg == 2'h0) ? ISC_SBND : ISC_SFLT;
            end
            ET_STACK:   escIsc = (step_reg == SEQ_LAST) ? ISC_PNEW : ISC_POLD;
            ET_PROCESS: escIsc = ISC_PNEW;
            ET_RESET:   escIsc = curIsc_reg;
        endcase
    end

    // ==================================================
    // Microsequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg  <= S_IDLE;
            curEt_reg  <= ET_NORMAL;
            curIsc_reg <= ISC_IDLE;
            step_reg   <= 2'h0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    step_reg <= 2'h0;
                    if (reqSel.valid) begin
                        state_reg  <= S_RUN;
                        curEt_reg  <= reqSel.et;
                        curIsc_reg <= reqSel.internal_state_code;
                    end
                end
                S_RUN: begin
                    if (escEv && curEt_reg == ET_RESET) begin
                        step_reg <= 2'h0;
                    end else if (escEv) begin
                        curEt_reg  <= curEt_reg - 2'h1;
                        curIsc_reg <= escIsc;
                        step_reg   <= 2'h0;
                    end else if (step_reg == SEQ_LAST) begin
                        state_reg <= S_DONE;
                    end else begin
                        step_reg <= step_reg + 2'h1;
                    end
                end
                S_DONE: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ==================================================
    // Status words seen by software and handlers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            psw_reg      <= PSW_IDLE;
            savedPsw_reg <= PSW_IDLE;
        end else if (state_reg == S_RUN) begin
            psw_reg      <= '{internal_state_code: curIsc_reg, tm: 1'b0, et: curEt_reg};
            savedPsw_reg <= '{internal_state_code: curIsc_reg, tm: 1'b0, et: ET_NORMAL};
        end else if (state_reg == S_DONE) begin
            unique case (curEt_reg)
                ET_NORMAL: begin
                    if (ctrl_reg[B_HSS]) begin
                        psw_reg <= '{internal_state_code: curIsc_reg, tm: 1'b0, et: ET_NORMAL};
                    end else begin
                        psw_reg <= PSW_GATE;
                    end
                end
                ET_STACK: psw_reg <= PSW_IDLE;
                default:  psw_reg <= '{internal_state_code: curIsc_reg, tm: 1'b0, et: ET_NORMAL};
            endcase
        end
    end

    // Gate indices only change on a gate-like completion
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gateIdx1_reg <= GATE_IDX1;
            gateIdx2_reg <= 8'h00;
        end else if (state_reg == S_DONE && curEt_reg == ET_NORMAL
                     && !ctrl_reg[B_HSS]) begin
            gateIdx1_reg <= GATE_IDX1;
            gateIdx2_reg <= {1'b0, curIsc_reg, 3'h0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vecAddr_reg <= VEC_RST;
        end else if (state_reg == S_RUN) begin
            unique case (curEt_reg)
                ET_NORMAL:  vecAddr_reg <= VEC_NRM;
                ET_STACK:   vecAddr_reg <= VEC_STK;
                ET_PROCESS: vecAddr_reg <= VEC_PRC;
                ET_RESET:   vecAddr_reg <= VEC_RST;
            endcase
        end
    end

    // Context save only for the stack class; it is raised on every stack run cycle, even one that a fault then cuts short
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seqBusy_reg  <= 1'b0;
            seqDone_reg  <= 1'b0;
            ctxSave_reg  <= 1'b0;
            pushPcbp_reg <= 1'b0;
            flagsUpd_reg <= 1'b0;
        end else begin
            seqBusy_reg  <= state_reg == S_RUN;
            seqDone_reg  <= state_reg == S_DONE;
            ctxSave_reg  <= state_reg == S_RUN && curEt_reg == ET_STACK;
            pushPcbp_reg <= state_reg == S_RUN && step_reg == 2'h0
                            && (curEt_reg == ET_STACK || curEt_reg == ET_PROCESS);
            flagsUpd_reg <= state_reg == S_IDLE && reqSel.valid && reqSel.et == ET_NORMAL
                            && (reqSel.internal_state_code == ISC_ZDIV || reqSel.internal_state_code == ISC_INVD
                             || reqSel.internal_state_code == ISC_RDT || reqSel.internal_state_code == ISC_PREG);
        end
    end

    // ==================================================
    // Register reads, unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdData_reg <= 32'h0;
        end else if (regRd) begin
            unique case (regAddr)
                OFS_CTRL:  regRdData_reg <= {28'h0, ctrl_reg};
                OFS_STAT:  regRdData_reg <= {23'h0, seqBusy_reg, 1'b0, psw_reg};
                OFS_SAVED: regRdData_reg <= {25'h0, savedPsw_reg};
                OFS_VEC:   regRdData_reg <= vecAddr_reg;
                default:   regRdData_reg <= 32'h0;
            endcase
        end else begin
            regRdData_reg <= 32'h0;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_escalate_class: assert property (
        state_reg == S_RUN && faultSync_reg && curEt_reg != ET_RESET
        |=> curEt_reg == $past(curEt_reg) - 2'h1 && step_reg == 2'h0)
        else $error("fault did not escalate class");
    a_reset_restart: assert property (
        state_reg == S_RUN && faultSync_reg && curEt_reg == ET_RESET
        |=> state_reg == S_RUN && curEt_reg == ET_RESET && step_reg == 2'h0)
        else $error("reset sequence not restarted");
    a_gate_status: assert property (
        state_reg == S_DONE && curEt_reg == ET_NORMAL && !ctrl_reg[B_HSS]
        |=> psw_reg == PSW_GATE && seqDone_reg)
        else $error("gate-like status wrong");
    a_gate_index: assert property (
        state_reg == S_DONE && curEt_reg == ET_NORMAL && !ctrl_reg[B_HSS]
        |=> gateIdx2_reg == {1'b0, $past(curIsc_reg), 3'h0} && gateIdx1_reg == GATE_IDX1)
        else $error("gate index wrong");
    a_switch_vector: assert property (
        state_reg == S_RUN && curEt_reg == ET_NORMAL && !escEv
        |=> vecAddr_reg == VEC_NRM)
        else $error("normal vector wrong");
    a_stack_status: assert property (
        state_reg == S_DONE && curEt_reg == ET_STACK
        |=> psw_reg == PSW_IDLE && savedPsw_reg.et == ET_NORMAL && !savedPsw_reg.tm)
        else $error("stack status wrong");
    a_proc_nosave: assert property (
        state_reg == S_RUN && curEt_reg == ET_PROCESS
        |=> !ctxSave_reg && vecAddr_reg == VEC_PRC)
        else $error("process class saved context");
    a_proc_code: assert property (
        state_reg == S_DONE && curEt_reg == ET_PROCESS
        |=> psw_reg.internal_state_code == $past(curIsc_reg) && psw_reg.et == ET_NORMAL && !psw_reg.tm)
        else $error("process code not copied");
    a_trace_req: assert property (
        state_reg == S_IDLE && instrEnd && ctrl_reg[B_TE]
        |-> reqSel.valid ##1 state_reg == S_RUN)
        else $error("trace trap missed");
    a_ovf_gate: assert property (
        !ovfPend_reg && ovfDet && !ctrl_reg[B_OE] |=> !ovfPend_reg)
        else $error("overflow raised while disabled");
    a_stack_bound: assert property (
        state_reg == S_RUN && curEt_reg == ET_NORMAL && step_reg == 2'h0 && stackBound
        |=> curEt_reg == ET_STACK && curIsc_reg == ISC_SBND)
        else $error("stack bound not escalated");

    c_gate_done: cover property (
        state_reg == S_DONE && curEt_reg == ET_NORMAL && !ctrl_reg[B_HSS]);
    c_stack_done: cover property (state_reg == S_DONE && curEt_reg == ET_STACK);
    c_reset_loop: cover property (
        state_reg == S_RUN && curEt_reg == ET_RESET && faultSync_reg);
endmodule : exms_core

//--- exms_mem_model.sv
`timescale 1ns/100ps
// ==========================================
// Memory system: raises its fault line for a burst of cycles
module exms_mem_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Burst request
    input  wire logic       go,
    input  wire logic [7:0] badLen,
    // Fault line toward the core
    output logic            memFault
);
    logic [7:0] cnt_reg;
    logic       go_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            go_reg  <= 1'b0;
        end else begin
            go_reg <= go;
            if (go && !go_reg) begin
                cnt_reg <= badLen;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
    // Fault follows the request at once, so it lands early in a sequence
    assign memFault = go | (cnt_reg != 8'h00);
endmodule : exms_mem_model

//--- testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench
    import exms_pkg::*;
;
    // ==========================================
    // Signals
    logic        clk_sys, rst_n, regWr, regRd, fltValid, instrEnd, ovfDet;
    logic        misalign, stackBound, idFetchFault, go, memFault;
    logic [3:0]  regAddr, fltCode;
    logic [31:0] regWrData, regRdData_reg, vecAddr_reg, rd;
    logic        seqBusy_reg, seqDone_reg, ctxSave_reg, pushPcbp_reg, flagsUpd_reg;
    logic [7:0]  gateIdx1_reg, gateIdx2_reg, badLen;
    exms_psw_t   psw_reg, savedPsw_reg;
    logic        sFlg, sPush, sCtx, sBusy;
    int          n_mismatch, n_compared, nWait;
    localparam logic [3:0] NCODE [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6,
                                          4'h7, 4'h8, 4'ha, 4'he, 4'hf};

    exms_core dut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData_reg, .fltValid, .fltCode, .instrEnd, .ovfDet, .misalign,
        .stackBound, .idFetchFault, .memFault, .seqBusy_reg, .seqDone_reg,
        .ctxSave_reg, .pushPcbp_reg, .flagsUpd_reg, .gateIdx1_reg, .gateIdx2_reg,
        .vecAddr_reg, .psw_reg, .savedPsw_reg);
    exms_mem_model mem (.clk_sys, .rst_n, .go, .badLen, .memFault);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================
    // Shared tasks
    function automatic exms_psw_t mk(input logic [3:0] c);
        mk = '{internal_state_code: c, tm: 1'b0, et: ET_NORMAL};
    endfunction : mk

    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        d = regRdData_reg;
    endtask : rdReg

    // Event order: go, idFetchFault, fltValid, misalign, ovfDet, instrEnd, stackBound
    task automatic kick(input logic [6:0] ev, input logic [3:0] c, input int len);
        @(posedge clk_sys);
        {go, idFetchFault, fltValid, misalign, ovfDet, instrEnd, stackBound} <= ev;
        fltCode <= c;
        repeat (len) @(posedge clk_sys);
        {go, idFetchFault, fltValid, misalign, ovfDet, instrEnd, stackBound} <= 7'h00;
    endtask : kick

    task automatic waitSeq(input logic want);
        {sFlg, sPush, sCtx, sBusy} = 4'h0;
        for (nWait = 0; nWait < 80; nWait++) begin
            @(negedge clk_sys);
            sFlg |= flagsUpd_reg;
            sPush |= pushPcbp_reg;
            sCtx |= ctxSave_reg;
            sBusy |= seqBusy_reg;
            if (want && seqDone_reg === 1'b1) return;
        end
        if (want) begin
            $display("BAD seqDone expected 1 seen 0");
            n_mismatch++;
            finish_test();
        end
    endtask : waitSeq

    // Enable bit b either silences or lets through the event ev
    task automatic gated(input int b, input logic [6:0] ev, input logic [3:0] c,
                         input logic setFires);
        wr(OFS_CTRL, 32'(!setFires) << b);
        kick(ev, 4'h0, 1);
        waitSeq(1'b0);
        `CHK("quiet busy", 1'b0, sBusy)
        wr(OFS_CTRL, 32'(setFires) << b);
        kick(ev, 4'h0, 1);
        waitSeq(1'b1);
        `CHK("gated code", mk(c), savedPsw_reg)
        wr(OFS_CTRL, 32'h0);
    endtask : gated

    // ==========================================
    // Scenarios
    task automatic tRegs;
        rdReg(OFS_STAT, rd);
        `CHK("stat", 32'(PSW_IDLE), rd)
        rdReg(OFS_SAVED, rd);
        `CHK("saved", 32'(PSW_IDLE), rd)
        rdReg(OFS_VEC, rd);
        `CHK("vec", VEC_RST, rd)
        rdReg(4'h2, rd);
        `CHK("unmapped", 32'h0, rd)
        wr(OFS_STAT, 32'hffff_ffff);
        rdReg(OFS_STAT, rd);
        `CHK("stat ro", 32'(PSW_IDLE), rd)
        wr(OFS_CTRL, 32'h0000_000f);
        rdReg(OFS_CTRL, rd);
        `CHK("ctrl", 32'h0000_000f, rd)
        wr(OFS_CTRL, 32'h0);
    endtask : tRegs

    task automatic tGate;
        logic fx;
        for (int i = 0; i < 10; i++) begin
            kick(7'h10, NCODE[i], 1);
            waitSeq(1'b1);
            fx = NCODE[i] inside {ISC_ZDIV, ISC_INVD, ISC_RDT, ISC_PREG};
            `CHK("flags", fx, sFlg)
            `CHK("psw", PSW_GATE, psw_reg)
            `CHK("saved", mk(NCODE[i]), savedPsw_reg)
            `CHK("idx1", GATE_IDX1, gateIdx1_reg)
            `CHK("idx2", {1'b0, NCODE[i], 3'h0}, gateIdx2_reg)
            `CHK("busy", 1'b1, sBusy)
        end
    endtask : tGate

    task automatic tSwitch;
        wr(OFS_CTRL, 32'h1 << B_HSS);
        kick(7'h10, 4'h2, 1);
        waitSeq(1'b1);
        `CHK("switch vec", VEC_NRM, vecAddr_reg)
        `CHK("switch psw", mk(4'h2), psw_reg)
        wr(OFS_CTRL, 32'h0);
    endtask : tSwitch

    task automatic tStack;
        // Bound is held so the sequence sees it in its first step
        kick(7'h11, 4'h2, 3);
        waitSeq(1'b1);
        `CHK("stk vec", VEC_STK, vecAddr_reg)
        `CHK("stk push", 1'b1, sPush)
        `CHK("stk save", 1'b1, sCtx)
        `CHK("stk psw", PSW_IDLE, psw_reg)
        `CHK("stk saved", mk(ISC_SBND), savedPsw_reg)
        kick(7'h38, 4'h2, 1);
        waitSeq(1'b1);
        `CHK("idf vec", VEC_STK, vecAddr_reg)
        `CHK("idf saved", mk(ISC_SIDF), savedPsw_reg)
    endtask : tStack

    task automatic tMem;
        badLen <= 8'h00;
        kick(7'h40, 4'h0, 1);
        waitSeq(1'b1);
        `CHK("ext saved", mk(ISC_EXTM), savedPsw_reg)
        // A one-cycle tail keeps the fault up into the first normal step only
        badLen <= 8'h01;
        kick(7'h40, 4'h0, 1);
        waitSeq(1'b1);
        `CHK("sflt saved", mk(ISC_SFLT), savedPsw_reg)
        `CHK("sflt vec", VEC_STK, vecAddr_reg)
        badLen <= 8'h00;
        kick(7'h60, 4'h0, 1);
        waitSeq(1'b1);
        `CHK("prc vec", VEC_PRC, vecAddr_reg)
        `CHK("prc push", 1'b1, sPush)
        `CHK("prc tm et", {1'b0, ET_NORMAL}, {psw_reg.tm, psw_reg.et})
        `CHK("prc isc", ISC_POLD, psw_reg.internal_state_code)
        badLen <= 8'h1e;
        kick(7'h60, 4'h0, 1);
        waitSeq(1'b1);
        `CHK("rst vec", VEC_RST, vecAddr_reg)
        `CHK("rst held", 1'b1, nWait >= 30)
        `CHK("rst tm et", {1'b0, ET_NORMAL}, {psw_reg.tm, psw_reg.et})
    endtask : tMem

    initial begin
        {rst_n, regWr, regRd, go} = 4'h0;
        {fltValid, instrEnd, ovfDet, misalign, stackBound, idFetchFault} = 6'h00;
        {regAddr, fltCode, badLen, regWrData} = '0;
        {n_mismatch, n_compared} = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tRegs();
        tGate();
        tSwitch();
        gated(B_TE, 7'h02, ISC_TRACE, 1'b1);
        gated(B_OE, 7'h04, ISC_OVF, 1'b1);
        gated(B_ABA, 7'h08, ISC_EXTM, 1'b0);
        tStack();
        tMem();
        finish_test();
    end
endmodule : testbench
